// [hw/perf_cfg.svh]
// Constants shared by the section performance counter ends.
// Assumes a 100 MHz system clock and byte addresses on the register bus.
`ifndef PERF_CFG_SVH
`define PERF_CFG_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PERF_SECTIONS 8
`define PERF_EVENTS 8
`define PERF_TIME_W 40
`define PERF_CNT_W 32
`define PERF_DIV_W 8

// ----------------------------------------
// Tick resolution
// ----------------------------------------
`define PERF_CLK_NS 10
`define PERF_RES_NS_0 10
`define PERF_RES_NS_1 20
`define PERF_RES_NS_2 40
`define PERF_RES_NS_3 80
`define PERF_RES_NS_4 160
`define PERF_RES_NS_5 1600
`define PERF_DIV(ns) ((ns) / `PERF_CLK_NS)
`define PERF_RES_DEF 3'h0

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define PERF_A_CTRL 8'h00
`define PERF_A_ENABLE 8'h04
`define PERF_A_MODE 8'h08
`define PERF_A_SEL 8'h0C
`define PERF_A_START 8'h10
`define PERF_A_END 8'h14
`define PERF_A_TOTAL_LO 8'h20
`define PERF_A_TOTAL_HI 8'h24
`define PERF_A_COUNT 8'h28
`define PERF_A_MAX_LO 8'h2C
`define PERF_A_MAX_HI 8'h30
`define PERF_A_MIN_LO 8'h34
`define PERF_A_MIN_HI 8'h38
`define PERF_A_RUN_LO 8'h3C
`define PERF_A_RUN_HI 8'h40
`define PERF_CTRL_CLR_ALL 0
`define PERF_CTRL_CLR_ONE 1
`define PERF_CTRL_RES_LO 8
`define PERF_CTRL_RES_HI 10
`define PERF_CTRL_RUNNING 16

`endif

// [hw/perf_pkg.sv]
// Types shared by the section performance counter ends.
// Assumes perf_cfg.svh is on the include path.
`include "perf_cfg.svh"

package perf_pkg;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [`PERF_TIME_W-1:0] time_t;
	typedef logic [`PERF_CNT_W-1:0] cnt_t;
	typedef enum logic [1:0] {MODE_BETWEEN, MODE_START_START, MODE_IRQ_OFF, MODE_IRQ_ON} mode_e;
	typedef enum logic [2:0] {FIELD_TOTAL, FIELD_COUNT, FIELD_MAX, FIELD_MIN, FIELD_RUN} field_e;

	// One section's measurement state
	typedef struct packed {
		logic win;
		logic meas;
		time_t cur;
		time_t total;
		cnt_t cnt;
		time_t max;
		time_t min;
	} sec_s;
endpackage : perf_pkg

// [hw/perf_link_if.sv]
// Link between the host controller and the measurement unit.
// Both ends run on the same clk_sys; no crossing is needed here.
`timescale 1ns/1ps
`include "perf_cfg.svh"

interface perf_link_if;
	logic [`PERF_SECTIONS-1:0] enable;
	logic [`PERF_SECTIONS-1:0][1:0] mode;
	logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] start_mask;
	logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] end_mask;
	logic [2:0] resolution;
	logic clear_all;
	logic clear_one;
	logic [2:0] clear_sel;
	logic [2:0] rd_sec;
	perf_pkg::field_e rd_field;
	perf_pkg::time_t rd_data;
	logic running;

	modport dev (
		input enable, mode, start_mask, end_mask, resolution,
		input clear_all, clear_one, clear_sel, rd_sec, rd_field,
		output rd_data, running
	);
	modport host (
		output enable, mode, start_mask, end_mask, resolution,
		output clear_all, clear_one, clear_sel, rd_sec, rd_field,
		input rd_data, running
	);
endinterface : perf_link_if

// [hw/perf_counter_unit.sv]
// Measurement unit: times up to eight program sections of a target.
// Assumes target event, interrupt-off and run inputs are asynchronous pins.
//
// Summary of operation
// - Eight sections: total, count, max, min
// - Passive observation; target is never stalled
// - Host changes settings only while halted
// - One of four modes per section
// - Event occurrence count always one
// - Irq mode: time runs while interrupts off
// - Irq mode: count each entry into off
// - Any of several events marks boundary
// - Shared tick: 10ns to 1.6us, 10ns default
// - Measures while running, readable when halted
// - Resume without clear keeps accumulating
// - Clear one section or all sections
// - Time accumulators are 40-bit tick counts
// - Pass count is a 32-bit counter
// - Results may be off by one tick
// - Share is total over run time
// - Disabled section does not measure
// - Function timing: entry start, every exit end
`timescale 1ns/1ps
`include "perf_cfg.svh"

module perf_counter_unit (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Host link
	perf_link_if.dev link,
	// Target observation pins
	input wire logic [`PERF_EVENTS-1:0] evt_in,
	input wire logic irq_off_in,
	input wire logic run_in
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [`PERF_EVENTS-1:0] evt_s1;
		logic [`PERF_EVENTS-1:0] evt_s2;
		logic [`PERF_EVENTS-1:0] evt_prev;
		logic irq_s1;
		logic irq_s2;
		logic irq_prev;
		logic run_s1;
		logic run_s2;
		logic [`PERF_DIV_W-1:0] div;
		perf_pkg::time_t runtime;
		perf_pkg::time_t rd_data;
		perf_pkg::sec_s [`PERF_SECTIONS-1:0] sec;
	} dev_s;

	dev_s st;
	dev_s next_st;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Saturating increments keep an overflow visible
	function automatic perf_pkg::time_t sat_time(input perf_pkg::time_t v);
		sat_time = (&v) ? v : v + 1'b1;
	endfunction : sat_time

	function automatic perf_pkg::cnt_t sat_cnt(input perf_pkg::cnt_t v);
		sat_cnt = (&v) ? v : v + 1'b1;
	endfunction : sat_cnt

	// Any selected event in a boundary set fires it
	function automatic logic hit(input logic [`PERF_EVENTS-1:0] mask,
		input logic [`PERF_EVENTS-1:0] rise);
		hit = |(mask & rise);
	endfunction : hit

	// Clock cycles per tick for each resolution code
	function automatic logic [`PERF_DIV_W-1:0] div_of(input logic [2:0] res);
		case (res)
			3'h1: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_1));
			3'h2: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_2));
			3'h3: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_3));
			3'h4: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_4));
			3'h5: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_5));
			default: div_of = `PERF_DIV_W'(`PERF_DIV(`PERF_RES_NS_0));
		endcase
	endfunction : div_of

	// Cleared section: min starts high so the first interval wins
	function automatic perf_pkg::sec_s sec_clear();
		sec_clear = '0;
		sec_clear.min = '1;
	endfunction : sec_clear

	// Close one interval into max and min
	function automatic perf_pkg::sec_s close_iv(input perf_pkg::sec_s s);
		close_iv = s;
		if (s.cur > s.max) begin
			close_iv.max = s.cur;
		end
		if (s.cur < s.min) begin
			close_iv.min = s.cur;
		end
		close_iv.meas = 1'b0;
	endfunction : close_iv

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.rd_data = st.rd_data;
	assign link.running = st.run_s2;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Observation only: no output ever reaches the target
	always_comb begin
		logic tick;
		logic run;
		logic [`PERF_EVENTS-1:0] rise;
		logic lvl;
		logic lvl_prev;
		logic s_hit;
		logic e_hit;
		perf_pkg::mode_e m;
		perf_pkg::sec_s s;
		tick = 1'b0;
		run = st.run_s2;
		rise = st.evt_s2 & ~st.evt_prev;
		lvl = 1'b0;
		lvl_prev = 1'b0;
		s_hit = 1'b0;
		e_hit = 1'b0;
		m = perf_pkg::MODE_BETWEEN;
		s = '0;
		next_st = st;

		// Two-stage synchronisers, edge history from stage two only
		next_st.evt_s1 = evt_in;
		next_st.evt_s2 = st.evt_s1;
		next_st.evt_prev = st.evt_s2;
		next_st.irq_s1 = irq_off_in;
		next_st.irq_s2 = st.irq_s1;
		next_st.irq_prev = st.irq_s2;
		next_st.run_s1 = run_in;
		next_st.run_s2 = st.run_s1;

		// Shared tick prescaler, held at zero while halted
		if (run) begin
			tick = (st.div == div_of(link.resolution) - 1'b1);
			next_st.div = tick ? '0 : st.div + 1'b1;
		end else begin
			next_st.div = '0;
		end

		// Go-to-break run time, the divisor of each share
		if (tick) begin
			next_st.runtime = sat_time(st.runtime);
		end

		for (int i = 0; i < `PERF_SECTIONS; i++) begin
			s = st.sec[i];
			m = perf_pkg::mode_e'(link.mode[i]);
			// A single occurrence is a boundary; no repeat count exists
			s_hit = hit(link.start_mask[i], rise);
			e_hit = hit(link.end_mask[i], rise);
			lvl = (m == perf_pkg::MODE_IRQ_OFF) ? st.irq_s2 : ~st.irq_s2;
			lvl_prev = (m == perf_pkg::MODE_IRQ_OFF) ? st.irq_prev : ~st.irq_prev;
			if (!link.enable[i]) begin
				s.win = 1'b0;
				s.meas = 1'b0;
			end else if (run) begin
				// Tick lands before any close, so error stays within a tick
				if (s.meas && tick) begin
					s.cur = sat_time(s.cur);
					s.total = sat_time(s.total);
				end
				case (m)
					perf_pkg::MODE_BETWEEN: begin
						if (s.win && e_hit) begin
							s = close_iv(s);
							s.cnt = sat_cnt(s.cnt);
							s.win = 1'b0;
						end else if (!s.win && s_hit) begin
							s.win = 1'b1;
							s.meas = 1'b1;
							s.cur = '0;
						end
					end
					perf_pkg::MODE_START_START: begin
						if (s_hit) begin
							if (s.win) begin
								s = close_iv(s);
								s.cnt = sat_cnt(s.cnt);
							end
							s.win = 1'b1;
							s.meas = 1'b1;
							s.cur = '0;
						end
					end
					perf_pkg::MODE_IRQ_OFF, perf_pkg::MODE_IRQ_ON: begin
						if (s.meas && (!lvl || (s.win && e_hit))) begin
							s = close_iv(s);
						end
						if (s.win && e_hit) begin
							s.win = 1'b0;
						end else if (!s.win && s_hit) begin
							s.win = 1'b1;
						end
						if (s.win && !s.meas && lvl && (!lvl_prev || s_hit)) begin
							s.meas = 1'b1;
							s.cur = '0;
							s.cnt = sat_cnt(s.cnt);
						end
					end
					default: begin
						s.win = 1'b0;
					end
				endcase
			end
			// Host clears take effect over any same-cycle update
			if (link.clear_all || (link.clear_one && link.clear_sel == 3'(i))) begin
				s = sec_clear();
			end
			next_st.sec[i] = s;
		end

		if (link.clear_all) begin
			next_st.runtime = '0;
		end

		// Readout mux, registered so the host sees a flop
		case (link.rd_field)
			perf_pkg::FIELD_TOTAL: next_st.rd_data = st.sec[link.rd_sec].total;
			perf_pkg::FIELD_COUNT: begin
				next_st.rd_data = perf_pkg::time_t'(st.sec[link.rd_sec].cnt);
			end
			perf_pkg::FIELD_MAX: next_st.rd_data = st.sec[link.rd_sec].max;
			perf_pkg::FIELD_MIN: next_st.rd_data = st.sec[link.rd_sec].min;
			perf_pkg::FIELD_RUN: next_st.rd_data = st.runtime;
			default: next_st.rd_data = '0;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset leaves every section cleared and idle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			for (int i = 0; i < `PERF_SECTIONS; i++) begin
				st.sec[i].min <= '1;
			end
		end else begin
			st <= next_st;
		end
	end
endmodule : perf_counter_unit

// [hw/perf_host_ctrl.sv]
// Host controller: classic Wishbone slave holding the measurement settings.
// Assumes the measurement unit on the link shares clk_sys.
`timescale 1ns/1ps
`include "perf_cfg.svh"

module perf_host_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Measurement link
	perf_link_if.host link,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic pend;
		logic ack;
		logic [31:0] dat;
		logic [2:0] res;
		logic [`PERF_SECTIONS-1:0] enable;
		logic [`PERF_SECTIONS-1:0][1:0] mode;
		logic [2:0] sel;
		logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] start;
		logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] occ;
		logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] endm;
		logic clr_all;
		logic clr_one;
	} hst_s;

	hst_s st;
	hst_s next_st;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = sel[b] ? d[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction : merge

	// Result field addressed by a read
	function automatic perf_pkg::field_e field_of(input logic [7:0] a);
		case (a)
			`PERF_A_COUNT: field_of = perf_pkg::FIELD_COUNT;
			`PERF_A_MAX_LO, `PERF_A_MAX_HI: field_of = perf_pkg::FIELD_MAX;
			`PERF_A_MIN_LO, `PERF_A_MIN_HI: field_of = perf_pkg::FIELD_MIN;
			`PERF_A_RUN_LO, `PERF_A_RUN_HI: field_of = perf_pkg::FIELD_RUN;
			default: field_of = perf_pkg::FIELD_TOTAL;
		endcase
	endfunction : field_of

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.enable = st.enable;
	assign link.mode = st.mode;
	assign link.start_mask = st.start;
	assign link.end_mask = st.endm;
	assign link.resolution = st.res;
	assign link.clear_all = st.clr_all;
	assign link.clear_one = st.clr_one;
	assign link.clear_sel = st.sel;
	assign link.rd_sec = st.sel;
	assign link.rd_field = field_of(wb_adr_i);
	assign wb_dat_o = st.dat;
	assign wb_ack_o = st.ack;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Answer two cycles after the request, giving the unit a cycle to mux
	always_comb begin
		logic [31:0] rd;
		logic wr;
		rd = '0;
		wr = 1'b0;
		next_st = st;
		next_st.clr_all = 1'b0;
		next_st.clr_one = 1'b0;
		next_st.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !st.pend && !st.ack) begin
			next_st.pend = 1'b1;
		end
		if (st.pend) begin
			next_st.pend = 1'b0;
			next_st.ack = 1'b1;
			wr = wb_we_i;
			case (wb_adr_i)
				`PERF_A_CTRL: begin
					rd[`PERF_CTRL_RES_HI:`PERF_CTRL_RES_LO] = st.res;
					rd[`PERF_CTRL_RUNNING] = link.running;
				end
				`PERF_A_ENABLE: rd = 32'(st.enable);
				`PERF_A_MODE: rd = 32'(st.mode);
				`PERF_A_SEL: rd = 32'(st.sel);
				`PERF_A_START: rd = {16'h0000, st.occ[st.sel], st.start[st.sel]};
				`PERF_A_END: rd = 32'(st.endm[st.sel]);
				`PERF_A_TOTAL_LO, `PERF_A_MAX_LO, `PERF_A_MIN_LO, `PERF_A_RUN_LO,
				`PERF_A_COUNT: rd = link.rd_data[31:0];
				`PERF_A_TOTAL_HI, `PERF_A_MAX_HI, `PERF_A_MIN_HI, `PERF_A_RUN_HI: begin
					rd = 32'(link.rd_data[`PERF_TIME_W-1:32]);
				end
				default: rd = '0;
			endcase
			next_st.dat = rd;
			// Settings are frozen while the target runs
			if (wr && !link.running) begin
				rd = merge(rd, wb_dat_i, wb_sel_i);
				case (wb_adr_i)
					`PERF_A_CTRL: begin
						next_st.res = rd[`PERF_CTRL_RES_HI:`PERF_CTRL_RES_LO];
						next_st.clr_all = rd[`PERF_CTRL_CLR_ALL];
						next_st.clr_one = rd[`PERF_CTRL_CLR_ONE];
					end
					`PERF_A_ENABLE: next_st.enable = rd[`PERF_SECTIONS-1:0];
					`PERF_A_MODE: next_st.mode = rd[2*`PERF_SECTIONS-1:0];
					`PERF_A_SEL: next_st.sel = rd[2:0];
					`PERF_A_START: begin
						next_st.start[st.sel] = rd[`PERF_EVENTS-1:0];
						// Stored for readback only; the unit always uses one
						next_st.occ[st.sel] = rd[2*`PERF_EVENTS-1:`PERF_EVENTS];
					end
					`PERF_A_END: next_st.endm[st.sel] = rd[`PERF_EVENTS-1:0];
					default: next_st.sel = st.sel;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.res <= `PERF_RES_DEF;
		end else begin
			st <= next_st;
		end
	end
endmodule : perf_host_ctrl

// [verif/perf_link_asserts.sv]
// Checker for the link between the host controller and the measurement unit.
// Assumes one clock domain; the link signals come in as plain inputs.
`timescale 1ns/1ps
`include "perf_cfg.svh"

module perf_link_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Settings from the host end
	input wire logic [`PERF_SECTIONS-1:0] enable,
	input wire logic [`PERF_SECTIONS-1:0][1:0] mode,
	input wire logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] start_mask,
	input wire logic [`PERF_SECTIONS-1:0][`PERF_EVENTS-1:0] end_mask,
	input wire logic [2:0] resolution,
	// Clears and readout
	input wire logic clear_all,
	input wire logic clear_one,
	input wire logic [2:0] clear_sel,
	input wire logic [2:0] rd_sec,
	input perf_pkg::field_e rd_field,
	input perf_pkg::time_t rd_data,
	input wire logic running
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Long enough halted for the sync stages to drain
	sequence s_halted;
		!running [*4];
	endsequence
	sequence s_all_then_count;
		clear_all ##1 !running ##1 (!running && rd_field == perf_pkg::FIELD_COUNT);
	endsequence
	sequence s_one_then_count;
		clear_one ##1 !running ##1 (!running && rd_sec == $past(clear_sel, 2)
			&& rd_field == perf_pkg::FIELD_COUNT);
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_clr_all_pulse;
		clear_all |=> !clear_all;
	endproperty
	property p_clr_one_pulse;
		clear_one |=> !clear_one;
	endproperty
	// Host takes a clear only when it saw the target halted
	property p_clr_halted;
		(clear_all || clear_one) |-> !$past(running);
	endproperty
	property p_cfg_frozen;
		(running && $past(running))
			|-> $stable({enable, mode, start_mask, end_mask, resolution});
	endproperty
	property p_clr_all_zero;
		s_all_then_count |=> rd_data == 40'h0;
	endproperty
	property p_clr_one_zero;
		s_one_then_count |=> rd_data == 40'h0;
	endproperty
	property p_cnt_width;
		rd_field == perf_pkg::FIELD_COUNT |=> rd_data[39:32] == 8'h0;
	endproperty
	// Nothing moves while halted and the readout select holds
	property p_freeze;
		s_halted ##0 ($stable(rd_sec) && $stable(rd_field) && !$past(clear_all)
			&& !$past(clear_one)) |=> $stable(rd_data);
	endproperty

	a_clr_all_pulse: assert property (p_clr_all_pulse)
		else $error("clear all pulse longer than one cycle");
	a_clr_one_pulse: assert property (p_clr_one_pulse)
		else $error("clear one pulse longer than one cycle");
	a_clr_halted: assert property (p_clr_halted)
		else $error("clear issued while running");
	a_cfg_frozen: assert property (p_cfg_frozen)
		else $error("settings changed while running");
	a_clr_all_zero: assert property (p_clr_all_zero)
		else $error("count not zero after clear all");
	a_clr_one_zero: assert property (p_clr_one_zero)
		else $error("count not zero after clear one");
	a_cnt_width: assert property (p_cnt_width)
		else $error("pass count wider than 32 bits");
	a_freeze: assert property (p_freeze)
		else $error("results moved while halted");
endmodule : perf_link_asserts

// [verif/tb.sv]
// Self-checking bench: host controller and measurement unit joined by the link.
// Assumes both design ends and the link checker are compiled first.
`timescale 1ns/1ps
`include "perf_cfg.svh"

module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic [7:0] evt_in = 8'h0;
	logic irq_off_in = 1'b0;
	logic run_in = 1'b0;
	logic [31:0] q;
	logic [39:0] v;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	perf_link_if link ();
	perf_host_ctrl i_perf_host_ctrl (.clk_sys(clk_sys), .reset_n(reset_n), .link(link),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack));
	perf_counter_unit i_perf_counter_unit (.clk_sys(clk_sys), .reset_n(reset_n),
		.link(link), .evt_in(evt_in), .irq_off_in(irq_off_in), .run_in(run_in));
	perf_link_asserts i_perf_link_asserts (.clk_sys(clk_sys), .reset_n(reset_n),
		.enable(link.enable), .mode(link.mode), .start_mask(link.start_mask),
		.end_mask(link.end_mask), .resolution(link.resolution),
		.clear_all(link.clear_all), .clear_one(link.clear_one),
		.clear_sel(link.clear_sel), .rd_sec(link.rd_sec), .rd_field(link.rd_field),
		.rd_data(link.rd_data), .running(link.running));

	// Cycle ceiling; a hang ends in the report
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// Tolerance covers the one-tick quantisation error
	task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g,
		input int tol);
		samples_checked++;
		if ((^g) === 1'bx || (tol == 0 && g !== e) || g > {1'b0, e} + tol
			|| {1'b0, g} + tol < e) begin
			errors++;
			$display("unexpected %s: expected %0d seen %0d", nm, e, g);
		end
	endtask : chk

	// Classic cycle; only the bench timeout ends the wait for ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do @(posedge clk_sys); while (wb_ack !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb

	// Low word first, both read while halted
	task automatic rd40(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
		v[31:0] = q;
		wb(1'b0, a + 8'h4, 32'h0);
		v[39:32] = q[7:0];
	endtask : rd40

	task automatic w(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : w

	task automatic ev(input int i);
		evt_in[i] <= 1'b1;
		w(1);
		evt_in[i] <= 1'b0;
	endtask : ev

	task automatic off(input int n);
		irq_off_in <= 1'b1;
		w(n);
		irq_off_in <= 1'b0;
	endtask : off

	// Run level change plus sync settling
	task automatic run(input logic on);
		run_in <= on;
		w(6);
	endtask : run

	task automatic cfg(input logic [2:0] s, input logic [31:0] st, input logic [7:0] en);
		wb(1'b1, `PERF_A_SEL, {29'h0, s});
		wb(1'b1, `PERF_A_START, st);
		wb(1'b1, `PERF_A_END, {24'h0, en});
	endtask : cfg

	task automatic res(input logic [2:0] s, input logic [39:0] c, t, input int tt,
		input logic [39:0] mx, mn);
		wb(1'b1, `PERF_A_SEL, {29'h0, s});
		wb(1'b0, `PERF_A_COUNT, 32'h0);
		chk("count", c, {8'h0, q}, 0);
		rd40(`PERF_A_TOTAL_LO);
		chk("total", t, v, tt);
		rd40(`PERF_A_MAX_LO);
		chk("max", mx, v, 1);
		rd40(`PERF_A_MIN_LO);
		chk("min", mn, v, 1);
	endtask : res

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		wb(1'b0, `PERF_A_CTRL, 32'h0);
		chk("ctrl", 40'h0, {8'h0, q}, 0);
		wb(1'b0, 8'hFC, 32'h0);
		chk("unmapped", 40'h0, {8'h0, q}, 0);
		res(3'h0, 40'h0, 40'h0, 0, 40'h0, 40'hFFFFFFFFFF);
		wb(1'b1, `PERF_A_MODE, 32'hE4);
		wb(1'b0, `PERF_A_MODE, 32'h0);
		chk("mode", 40'hE4, {8'h0, q}, 0);
		wb(1'b1, `PERF_A_ENABLE, 32'h0F);
		cfg(3'h0, 32'h0501, 8'h06);
		cfg(3'h1, 32'h01, 8'h00);
		cfg(3'h2, 32'h08, 8'h10);
		cfg(3'h3, 32'h08, 8'h10);
		cfg(3'h4, 32'h01, 8'h06);
	endtask : t_reset

	// Repeated start while open is ignored; either end event closes
	task automatic t_between();
		run(1'b1);
		wb(1'b0, `PERF_A_CTRL, 32'h0);
		chk("running", 40'h1, {39'h0, q[`PERF_CTRL_RUNNING]}, 0);
		ev(0); w(9); ev(0); w(9); ev(2); w(5); ev(0); w(39); ev(1); w(5);
		run(1'b0);
		res(3'h0, 40'h2, 40'd60, 2, 40'd40, 40'd20);
		res(3'h4, 40'h0, 40'h0, 0, 40'h0, 40'hFFFFFFFFFF);
		// Start-to-start: intervals of 10 and 16, third still open at halt
		res(3'h1, 40'h2, 40'd71, 2, 40'd16, 40'd10);
	endtask : t_between

	// Writes and clears while running are dropped; results accumulate
	task automatic t_resume();
		run(1'b1);
		wb(1'b1, `PERF_A_ENABLE, 32'h0);
		wb(1'b1, `PERF_A_CTRL, 32'h1);
		wb(1'b0, `PERF_A_ENABLE, 32'h0);
		chk("enable", 40'h0F, {8'h0, q}, 0);
		ev(0); w(29); ev(2); w(5);
		run(1'b0);
		res(3'h0, 40'h3, 40'd90, 3, 40'd40, 40'd20);
	endtask : t_resume

	// Off time counted only inside the window
	task automatic t_irq();
		run(1'b1);
		off(5); w(3); ev(3); w(3); off(10); w(5); off(15); w(3); ev(4); w(3); off(8);
		run(1'b0);
		res(3'h2, 40'h2, 40'd25, 2, 40'd15, 40'd10);
		// Enabled-time mode sees the complementary intervals of 4, 5 and 3
		res(3'h3, 40'h3, 40'd12, 2, 40'd5, 40'd3);
	endtask : t_irq

	task automatic t_clear();
		wb(1'b1, `PERF_A_SEL, 32'h2);
		wb(1'b1, `PERF_A_CTRL, 32'h2);
		wb(1'b0, `PERF_A_COUNT, 32'h0);
		chk("count one", 40'h0, {8'h0, q}, 0);
		res(3'h0, 40'h3, 40'd90, 3, 40'd40, 40'd20);
		wb(1'b1, `PERF_A_CTRL, 32'h1);
		wb(1'b0, `PERF_A_COUNT, 32'h0);
		chk("count all", 40'h0, {8'h0, q}, 0);
		res(3'h2, 40'h0, 40'h0, 0, 40'h0, 40'hFFFFFFFFFF);
	endtask : t_clear

	// 80 ns tick: 80 cycles make 10 ticks
	task automatic t_res();
		wb(1'b1, `PERF_A_CTRL, 32'h300);
		wb(1'b0, `PERF_A_CTRL, 32'h0);
		chk("ctrl", 40'h300, {8'h0, q}, 0);
		run(1'b1);
		ev(0); w(79); ev(2); w(5);
		run(1'b0);
		res(3'h0, 40'h1, 40'd10, 1, 40'd10, 40'd10);
		// Go-to-break time: about 92 running cycles at 8 cycles a tick
		rd40(`PERF_A_RUN_LO);
		chk("run time", 40'd11, v, 1);
	endtask : t_res

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_reset();
		t_between();
		t_resume();
		t_irq();
		t_clear();
		t_res();
		final_report();
	end
endmodule : tb
